// ===== core/pp_device.sv
// device end of the system processor parallel port
// assumes the processor keeps its own strobe, select and interrupt rules
// How it works
// - 32-bit shared data bus, little-endian
// - processor addresses registers with 8 bits
// - select low means device selected
// - read strobe low reads a location
// - write strobe low writes a location
// - wait goes low on select
// - busy high means do not interrupt
// - more line marks programmed-io entry/exit
// - processor raises inbound interrupt high
// - device raises outbound interrupt high
// - programming lines used only for programming
// - dma request low, acknowledge low handshake
`timescale 1ns/1ps
module pp_device
  import pp_pkg::*;
#(
  parameter int DW = DATA_W,
  parameter int AW = ADDR_W
) (
  input  wire logic          mclk,          // clock
  input  wire logic          sys_rst,       // sync reset, high
  pp_if.device               bus,           // pins to the processor
  output logic               acc_valid,     // access waiting for user
  output logic               acc_write,     // access is a write
  output logic               acc_dma,       // access is a dma beat
  output logic      [AW-1:0] acc_addr,      // access address
  output logic      [DW-1:0] acc_wdata,     // write data
  input  wire logic [DW-1:0] acc_rdata,     // read data from user
  input  wire logic          acc_done,      // user finished access
  input  wire logic          dma_req,       // user wants dma
  input  wire logic          busy_in,       // user cannot be interrupted
  input  wire logic          host_irq,      // user event for processor
  input  wire logic          ready_in,      // programming ready
  input  wire logic          done_in,       // programming done
  output logic               pio_more,      // more line level
  output logic               dev_irq,       // inbound interrupt pulse
  output logic               mode_a_mode,     // programming mode level
  output logic               mode_a_select    // controller select level
);
  localparam int SW = DW + AW + 8;
  localparam logic [SW-1:0] SYNC_RST = {{(DW + AW){1'b0}}, STRB_RST, STRB_RST, STRB_RST, STRB_RST, 4'h0};

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SEL,
    ST_CAPT,
    ST_USER,
    ST_DONE
  } dev_state_t;

  dev_state_t    state_ff;
  dev_state_t    nxt_state;
  logic [SW-1:0] sync_out;
  logic [DW-1:0] s_data;
  logic [AW-1:0] s_addr;
  logic          s_cs_n;
  logic          s_oe_n;
  logic          s_we_n;
  logic          s_ack_n;
  logic          s_more;
  logic          s_irq;
  logic          s_mode;
  logic          s_select;
  logic          cs_low;
  logic          dack_low;
  logic          sel_any;
  logic          strobe;
  logic          wait_n_ff;
  logic          nxt_wait_n;
  logic [DW-1:0] d_out_ff;
  logic          rd_ff;
  logic          wr_ff;
  logic          dma_ff;
  logic [AW-1:0] addr_ff;
  logic [DW-1:0] wdata_ff;
  logic          req_n_ff;
  logic          busy_ff;
  logic          irq_out_ff;
  logic          ready_ff;
  logic          done_ff;
  logic          irq_prev_ff;
  logic          more_ff;
  logic          mode_ff;
  logic          select_ff;
  logic          irq_pulse_ff;

  pp_sync2 #(
    .W       (SW),
    .RST_VAL (SYNC_RST)
  ) u_sync (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .din     ({bus.data, bus.addr, bus.cs_n, bus.oe_n, bus.we_n, bus.dma_ack_n,
                bus.more, bus.irq_to_device, bus.mode_a, bus.ctl_select}),
    .dout    (sync_out)
  );

  assign {s_data, s_addr, s_cs_n, s_oe_n, s_we_n, s_ack_n, s_more, s_irq, s_mode, s_select} = sync_out;

  assign cs_low   = ~s_cs_n;
  assign dack_low = ~s_ack_n;
  assign sel_any  = cs_low | dack_low;
  assign strobe   = sel_any & (~s_oe_n | ~s_we_n);

  // access sequencer
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_IDLE: begin
        if (sel_any) begin
          nxt_state = ST_SEL;
        end
      end
      ST_SEL: begin
        if (!sel_any) begin
          nxt_state = ST_IDLE;
        end else if (strobe) begin
          nxt_state = ST_CAPT;
        end
      end
      ST_CAPT: begin
        nxt_state = ST_USER;
      end
      ST_USER: begin
        if (acc_done) begin
          nxt_state = ST_DONE;
        end
      end
      ST_DONE: begin
        // one access per select, so wait stays released until deselect
        if (!sel_any) begin
          nxt_state = ST_IDLE;
        end
      end
    endcase
  end

  // wait low while selected, high one edge after read data is loaded
  assign nxt_wait_n = ~(cs_low & (state_ff != ST_DONE));

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_ff  <= ST_IDLE;
      wait_n_ff <= WAIT_RST;
    end else begin
      state_ff  <= nxt_state;
      wait_n_ff <= nxt_wait_n;
    end
  end

  // capture one cycle after the strobe so that data has settled
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rd_ff    <= 1'b0;
      wr_ff    <= 1'b0;
      dma_ff   <= 1'b0;
      addr_ff  <= '0;
      wdata_ff <= '0;
    end else if (state_ff == ST_CAPT) begin
      rd_ff    <= ~s_oe_n;
      wr_ff    <= ~s_we_n;
      dma_ff   <= dack_low;
      addr_ff  <= s_addr;
      wdata_ff <= s_data;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      d_out_ff <= '0;
    end else if (state_ff == ST_USER && acc_done && rd_ff) begin
      d_out_ff <= acc_rdata;
    end
  end

  assign acc_valid = (state_ff == ST_USER);
  assign acc_write = wr_ff;
  assign acc_dma   = dma_ff;
  assign acc_addr  = addr_ff;
  assign acc_wdata = wdata_ff;

  // bus driven only while selected and reading with data ready
  assign bus.dev_data_oe  = sel_any & ~s_oe_n & rd_ff & (state_ff == ST_DONE);
  assign bus.dev_data_out = d_out_ff;
  assign bus.wait_n       = wait_n_ff;

  // side lines
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      req_n_ff     <= DREQ_RST;
      busy_ff      <= 1'b0;
      irq_out_ff   <= 1'b0;
      ready_ff     <= 1'b0;
      done_ff      <= 1'b0;
      irq_prev_ff  <= 1'b0;
      irq_pulse_ff <= 1'b0;
      more_ff      <= 1'b0;
      mode_ff      <= 1'b0;
      select_ff    <= 1'b0;
    end else begin
      req_n_ff     <= ~(dma_req & ~dack_low);
      busy_ff      <= busy_in;
      irq_out_ff   <= host_irq;
      ready_ff     <= ready_in & s_mode;
      done_ff      <= done_in & s_mode;
      irq_prev_ff  <= s_irq;
      irq_pulse_ff <= s_irq & ~irq_prev_ff;
      more_ff      <= s_more;
      mode_ff      <= s_mode;
      select_ff    <= s_select & s_mode;
    end
  end

  assign bus.dma_request_n = req_n_ff;
  assign bus.busy          = busy_ff;
  assign bus.irq_to_host   = irq_out_ff;
  assign bus.mode_a_ready    = ready_ff;
  assign bus.mode_a_done     = done_ff;
  assign pio_more          = more_ff;
  assign dev_irq           = irq_pulse_ff;
  assign mode_a_mode         = mode_ff;
  assign mode_a_select       = select_ff;
endmodule // pp_device

// ===== core/pp_pkg.sv
// constants shared by both ends of the parallel processor port
// assumes a single 40 MHz clock on each end
package pp_pkg;
  localparam int DATA_W     = 32;
  localparam int ADDR_W     = 8;
  localparam int CLK_NS     = 25;
  // least times, rounded up to whole cycles
  localparam int T_CSS_NS   = 84;
  localparam int T_CSN_NS   = 84;
  localparam int T_DHW_NS   = 42;
  localparam int T_DMA_NS   = 546;
  localparam int T_DAI_NS   = 42;
  localparam int T_IIH_NS   = 504;
  localparam int CSS_CYC    = (T_CSS_NS + CLK_NS - 1) / CLK_NS;
  localparam int CSN_CYC    = (T_CSN_NS + CLK_NS - 1) / CLK_NS;
  localparam int DHW_CYC    = (T_DHW_NS + CLK_NS - 1) / CLK_NS;
  localparam int DMA_CYC    = (T_DMA_NS + CLK_NS - 1) / CLK_NS;
  localparam int DAI_CYC    = (T_DAI_NS + CLK_NS - 1) / CLK_NS;
  localparam int IIH_CYC    = (T_IIH_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W      = 5;
  // pin levels after reset
  localparam logic WAIT_RST = 1'b1;
  localparam logic DREQ_RST = 1'b1;
  localparam logic STRB_RST = 1'b1;
endpackage

// ===== core/pp_if.sv
// pins between the device end and the system processor end
// the shared data bus level is resolved here from the two enables
`timescale 1ns/1ps
interface pp_if #(
  parameter int DW = 32,
  parameter int AW = 8
);
  logic [DW-1:0] data;
  logic [DW-1:0] dev_data_out;
  logic          dev_data_oe;
  logic [DW-1:0] host_data_out;
  logic          host_data_oe;
  logic [AW-1:0] addr;
  logic          cs_n;
  logic          oe_n;
  logic          we_n;
  logic          wait_n;
  logic          busy;
  logic          more;
  logic          irq_to_device;
  logic          irq_to_host;
  logic          mode_a;
  logic          ctl_select;
  logic          mode_a_ready;
  logic          mode_a_done;
  logic          dma_request_n;
  logic          dma_ack_n;

  // device wins while it drives; a released bus reads low
  assign data = dev_data_oe ? dev_data_out : (host_data_oe ? host_data_out : '0);

  modport device (
    input  data, addr, cs_n, oe_n, we_n, more, irq_to_device, mode_a, ctl_select, dma_ack_n,
    output dev_data_out, dev_data_oe, wait_n, busy, irq_to_host, mode_a_ready, mode_a_done, dma_request_n
  );
  modport host (
    input  data, wait_n, busy, irq_to_host, mode_a_ready, mode_a_done, dma_request_n,
    output host_data_out, host_data_oe, addr, cs_n, oe_n, we_n, more, irq_to_device, mode_a,
           ctl_select, dma_ack_n
  );
endinterface

// ===== core/pp_sync2.sv
// two flip-flop synchroniser for a vector of pin inputs
// assumes each bit is a level from outside this clock domain
`timescale 1ns/1ps
module pp_sync2 #(
  parameter int             W       = 1,
  parameter logic [W-1:0]   RST_VAL = '0
) (
  input  wire logic         mclk,    // clock
  input  wire logic         sys_rst, // sync reset, high
  input  wire logic [W-1:0] din,     // async pins
  output logic      [W-1:0] dout     // synchronised
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] dout_ff;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      meta_ff <= RST_VAL;
      dout_ff <= RST_VAL;
    end else begin
      meta_ff <= din;
      dout_ff <= meta_ff;
    end
  end

  assign dout = dout_ff;
endmodule // pp_sync2

// ===== core/pp_host.sv
// system processor end of the parallel port
// assumes the device answers every select access by releasing wait; dma beats are timed by count
`timescale 1ns/1ps
module pp_host
  import pp_pkg::*;
#(
  parameter int DW = DATA_W,
  parameter int AW = ADDR_W
) (
  input  wire logic          mclk,        // clock
  input  wire logic          sys_rst,     // sync reset, high
  pp_if.host                 bus,         // pins to the device
  input  wire logic          cmd_valid,   // access request
  input  wire logic          cmd_write,   // 1 write, 0 read
  input  wire logic          cmd_dma,     // dma beat instead of select
  input  wire logic [AW-1:0] cmd_addr,    // address
  input  wire logic [DW-1:0] cmd_wdata,   // write data
  output logic               cmd_ready,   // request taken
  output logic               rsp_valid,   // access finished pulse
  output logic      [DW-1:0] rsp_rdata,   // read data
  output logic               dma_pending, // device requests dma
  input  wire logic          irq_req,     // raise inbound interrupt
  output logic               irq_active,  // inbound interrupt high
  input  wire logic          more_in,     // more line level
  input  wire logic          mode_in,     // programming mode
  input  wire logic          select_in,   // controller select
  output logic               dev_busy,    // device busy
  output logic               dev_irq,     // outbound interrupt level
  output logic               mode_a_ready,  // programming ready
  output logic               mode_a_done    // programming done
);
  localparam int SW = DW + 6;
  localparam logic [SW-1:0] SYNC_RST = {{DW{1'b0}}, WAIT_RST, DREQ_RST, 4'h0};

  typedef enum logic [2:0] {
    H_IDLE,
    H_SETUP,
    H_STROBE,
    H_HOLD,
    H_GAP
  } host_state_t;

  host_state_t      state_ff;
  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] irq_cnt_ff;
  logic [SW-1:0]    sync_out;
  logic [DW-1:0]    s_data;
  logic             s_wait_n;
  logic             s_req_n;
  logic             s_busy;
  logic             s_irq;
  logic             s_ready;
  logic             s_done;
  logic             wr_ff;
  logic             dma_ff;
  logic             seen_wait_ff;
  logic [AW-1:0]    addr_ff;
  logic [DW-1:0]    wdata_ff;
  logic             rsp_ff;
  logic [DW-1:0]    rdata_ff;
  logic             irq_ff;
  logic             side_more_ff;
  logic             side_mode_ff;
  logic             side_sel_ff;
  logic             take;
  logic             strobe_end;
  logic             pio_end;
  logic             dma_end;
  logic             setup_end;
  logic             hold_end;
  logic             gap_end;

  pp_sync2 #(
    .W       (SW),
    .RST_VAL (SYNC_RST)
  ) u_sync (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .din     ({bus.data, bus.wait_n, bus.dma_request_n, bus.busy, bus.irq_to_host, bus.mode_a_ready,
                bus.mode_a_done}),
    .dout    (sync_out)
  );

  assign {s_data, s_wait_n, s_req_n, s_busy, s_irq, s_ready, s_done} = sync_out;

  assign cmd_ready  = (state_ff == H_IDLE) & (~cmd_dma | ~s_req_n);
  assign take       = cmd_valid & cmd_ready;
  assign setup_end  = cnt_ff == CNT_W'(CSS_CYC - 1);
  assign pio_end    = seen_wait_ff & s_wait_n;
  assign dma_end    = cnt_ff == CNT_W'(DMA_CYC - 1);
  assign strobe_end = dma_ff ? dma_end : pio_end;
  assign hold_end   = cnt_ff == CNT_W'(DHW_CYC - 1);
  assign gap_end    = cnt_ff == CNT_W'((dma_ff ? DAI_CYC : CSN_CYC) - 1);

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_ff <= H_IDLE;
      cnt_ff   <= '0;
    end else begin
      cnt_ff <= cnt_ff + CNT_W'(1);
      unique case (state_ff)
        H_IDLE: begin
          cnt_ff <= '0;
          if (take) state_ff <= H_SETUP;
        end
        H_SETUP: if (setup_end) begin
          state_ff <= H_STROBE;
          cnt_ff   <= '0;
        end
        H_STROBE: if (strobe_end) begin
          state_ff <= H_HOLD;
          cnt_ff   <= '0;
        end
        H_HOLD: if (hold_end) begin
          state_ff <= H_GAP;
          cnt_ff   <= '0;
        end
        H_GAP: if (gap_end) state_ff <= H_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      wr_ff        <= 1'b0;
      dma_ff       <= 1'b0;
      addr_ff      <= '0;
      wdata_ff     <= '0;
      seen_wait_ff <= 1'b0;
      rsp_ff       <= 1'b0;
      rdata_ff     <= '0;
    end else begin
      rsp_ff <= (state_ff == H_STROBE) & strobe_end;
      if (take) begin
        wr_ff        <= cmd_write;
        dma_ff       <= cmd_dma;
        addr_ff      <= cmd_addr;
        wdata_ff     <= cmd_wdata;
        seen_wait_ff <= 1'b0;
      end else if (!s_wait_n) begin
        seen_wait_ff <= 1'b1;
      end
      if (state_ff == H_STROBE && strobe_end && !wr_ff) rdata_ff <= s_data;
    end
  end

  assign bus.cs_n          = ~(~dma_ff & (state_ff inside {H_SETUP, H_STROBE, H_HOLD}));
  assign bus.dma_ack_n     = ~(dma_ff & (state_ff inside {H_SETUP, H_STROBE, H_HOLD}));
  assign bus.oe_n          = ~(~wr_ff & (state_ff == H_STROBE));
  assign bus.we_n          = ~(wr_ff & (state_ff == H_STROBE));
  assign bus.host_data_oe  = wr_ff & (state_ff inside {H_SETUP, H_STROBE, H_HOLD});
  assign bus.host_data_out = wdata_ff;
  assign bus.addr          = addr_ff;
  assign rsp_valid         = rsp_ff;
  assign rsp_rdata         = rdata_ff;
  assign dma_pending       = ~s_req_n;

  // inbound interrupt held for its least width, never raised while busy
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      irq_ff       <= 1'b0;
      irq_cnt_ff   <= '0;
      side_more_ff <= 1'b0;
      side_mode_ff <= 1'b0;
      side_sel_ff  <= 1'b0;
    end else begin
      side_more_ff <= more_in;
      side_mode_ff <= mode_in;
      side_sel_ff  <= select_in & mode_in;
      if (irq_cnt_ff != '0) begin
        irq_cnt_ff <= irq_cnt_ff - CNT_W'(1);
        irq_ff     <= irq_cnt_ff != CNT_W'(1);
      end else if (irq_req && !s_busy) begin
        irq_cnt_ff <= CNT_W'(IIH_CYC);
        irq_ff     <= 1'b1;
      end
    end
  end

  assign bus.irq_to_device = irq_ff;
  assign bus.more          = side_more_ff;
  assign bus.mode_a        = side_mode_ff;
  assign bus.ctl_select    = side_sel_ff;
  assign irq_active        = irq_ff;
  assign dev_busy          = s_busy;
  assign dev_irq           = s_irq;
  assign mode_a_ready        = s_ready;
  assign mode_a_done         = s_done;
endmodule // pp_host

// ===== verification/pp_chk.sv
// assertions on the pins between the two port ends
// assumes one pp_if, one clock and a sync active-high reset
`timescale 1ns/1ps
module pp_chk (
  input wire logic mclk,          // clock
  input wire logic sys_rst,       // sync reset, high
  input wire logic cs_n,          // select
  input wire logic oe_n,          // read strobe
  input wire logic we_n,          // write strobe
  input wire logic wait_n,        // wait
  input wire logic dev_data_oe,   // device drives data
  input wire logic host_data_oe,  // processor drives data
  input wire logic dma_ack_n,     // dma acknowledge
  input wire logic dma_request_n, // dma request
  input wire logic mode_a,        // programming mode
  input wire logic mode_a_ready,    // programming ready
  input wire logic mode_a_done      // programming done
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  a_wait_on_select: assert property ($fell(cs_n) |-> ##[1:4] (!wait_n || cs_n))
    else $error("wait not low after select");
  a_wait_cause: assert property ($fell(wait_n) |-> !cs_n && ($past(cs_n, 2) == 1'b0))
    else $error("wait fell without select");
  a_unsel_wait_high: assert property (cs_n [*5] |-> wait_n)
    else $error("wait low while unselected");
  a_idle_bus_free: assert property ((cs_n && dma_ack_n) [*5] |-> !dev_data_oe)
    else $error("data driven while unselected");
  a_read_data_first: assert property ($rose(wait_n) && !oe_n |-> dev_data_oe && $past(dev_data_oe))
    else $error("wait released before read data");
  a_write_no_drive: assert property (!we_n |-> !dev_data_oe)
    else $error("device drives data during write");
  a_one_driver: assert property (!(dev_data_oe && host_data_oe))
    else $error("both ends drive data");
  a_dreq_on_ack: assert property ($fell(dma_ack_n) |-> ##[1:4] dma_request_n)
    else $error("request not withdrawn on acknowledge");
  a_mode_a_gated: assert property (!mode_a [*4] |-> !mode_a_ready && !mode_a_done)
    else $error("programming lines outside mode");
endmodule // pp_chk

// ===== verification/tb_system_processor_parallel_port.sv
// self-checking bench: host end and device end joined by one pp_if
// assumes a 40 MHz mclk; inputs change on the falling edge
`timescale 1ns/1ps
module tb_system_processor_parallel_port;
  import pp_pkg::*;
  logic              mclk, sys_rst, cmd_valid, cmd_write, cmd_dma, cmd_ready, rsp_valid, dma_pending;
  logic [ADDR_W-1:0] cmd_addr, acc_addr, exp_addr;
  logic [DATA_W-1:0] cmd_wdata, rsp_rdata, acc_wdata, acc_rdata, exp_data;
  logic              acc_valid, acc_write, acc_dma, acc_done, dma_req, busy_in, host_irq, ready_in, done_in;
  logic              pio_more, d_irq, mode_a_mode, mode_a_select, irq_req, irq_active, more_in, mode_in, select_in;
  logic              dev_busy, h_irq, h_ready, h_done, exp_wr, exp_dma;
  int                failures, num_checks, seed, cnt, irq_pulses;
  logic [DATA_W-1:0] ref_mem [int];
  logic [DATA_W-1:0] dev_mem [int];
  logic [ADDR_W-1:0] a_q [$];

  pp_if #(.DW(DATA_W), .AW(ADDR_W)) bus ();
  pp_device pp_device_i (.mclk(mclk), .sys_rst(sys_rst), .bus(bus), .acc_valid(acc_valid),
    .acc_write(acc_write), .acc_dma(acc_dma), .acc_addr(acc_addr), .acc_wdata(acc_wdata),
    .acc_rdata(acc_rdata), .acc_done(acc_done), .dma_req(dma_req), .busy_in(busy_in),
    .host_irq(host_irq), .ready_in(ready_in), .done_in(done_in), .pio_more(pio_more),
    .dev_irq(d_irq), .mode_a_mode(mode_a_mode), .mode_a_select(mode_a_select));
  pp_host pp_host_i (.mclk(mclk), .sys_rst(sys_rst), .bus(bus), .cmd_valid(cmd_valid),
    .cmd_write(cmd_write), .cmd_dma(cmd_dma), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
    .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .dma_pending(dma_pending),
    .irq_req(irq_req), .irq_active(irq_active), .more_in(more_in), .mode_in(mode_in),
    .select_in(select_in), .dev_busy(dev_busy), .dev_irq(h_irq), .mode_a_ready(h_ready),
    .mode_a_done(h_done));
  pp_chk pp_chk_i (.mclk(mclk), .sys_rst(sys_rst), .cs_n(bus.cs_n), .oe_n(bus.oe_n), .we_n(bus.we_n),
    .wait_n(bus.wait_n), .dev_data_oe(bus.dev_data_oe), .host_data_oe(bus.host_data_oe), .dma_ack_n(bus.dma_ack_n),
    .dma_request_n(bus.dma_request_n), .mode_a(bus.mode_a), .mode_a_ready(bus.mode_a_ready),
    .mode_a_done(bus.mode_a_done));

  task automatic chk(input string what, input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // one host access, compared with the reference memory
  task automatic access(input logic wr, input logic dma, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    int n;
    int key;
    key = dma ? 256 : int'(a);
    @(negedge mclk);
    exp_wr = wr;
    exp_dma = dma;
    exp_addr = a;
    exp_data = d;
    cmd_valid = 1'b1;
    cmd_write = wr;
    cmd_dma = dma;
    cmd_addr = a;
    cmd_wdata = d;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 400) begin
      n++;
      @(negedge mclk);
    end
    @(negedge mclk);
    cmd_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 400) begin
      n++;
      @(negedge mclk);
    end
    chk("rsp_valid", 32'(rsp_valid), 32'h1);
    if (wr)
      ref_mem[key] = d;
    else
      chk("rdata", rsp_rdata, ref_mem[key]);
  endtask

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    if (d_irq === 1'b1)
      irq_pulses++;
  end

  // user side of the device end
  initial begin : dev_user
    int key;
    int lat;
    forever begin
      @(negedge mclk);
      if (acc_valid === 1'b1) begin
        key = acc_dma ? 256 : int'(acc_addr);
        chk("kind", {30'h0, acc_dma, acc_write}, {30'h0, exp_dma, exp_wr});
        if (!exp_dma)
          chk("addr", 32'(acc_addr), 32'(exp_addr));
        if (acc_write) begin
          chk("wdata", acc_wdata, exp_data);
          chk("wire", bus.data, exp_data);
          dev_mem[key] = acc_wdata;
        end else
          acc_rdata = dev_mem[key];
        lat = $unsigned($random(seed)) % 4;
        repeat (lat) @(negedge mclk);
        acc_done = 1'b1;
        @(negedge mclk);
        acc_done = 1'b0;
      end
    end
  end

  initial begin
    #(CLK_NS * 20000);
    chk("watchdog", 32'h0, 32'h1);
    test_done;
  end

  initial begin
    seed = 47132;
    {sys_rst, cmd_valid, cmd_write, cmd_dma, acc_done, dma_req, busy_in, host_irq} = 8'hFF & 8'h80;
    {ready_in, done_in, irq_req, more_in, mode_in, select_in} = 6'h00;
    cmd_addr = '0;
    cmd_wdata = '0;
    acc_rdata = '0;
    repeat (6) @(negedge mclk);
    sys_rst = 1'b0;
    // boundary and random addresses, written then read back
    a_q = {8'h00, 8'hFF};
    repeat (4) a_q.push_back(8'($random(seed)));
    foreach (a_q[i]) access(1'b1, 1'b0, a_q[i], $random(seed));
    foreach (a_q[i]) access(1'b0, 1'b0, a_q[i], '0);
    $display("test pio done");
    dma_req = 1'b1;
    repeat (6) @(negedge mclk);
    chk("pending", 32'(dma_pending), 32'h1);
    access(1'b1, 1'b1, 8'h00, $random(seed));
    access(1'b0, 1'b1, 8'h00, '0);
    dma_req = 1'b0;
    repeat (8) @(negedge mclk);
    chk("dreq idle", {31'h0, bus.dma_request_n}, 32'h1);
    $display("test dma done");
    busy_in = 1'b1;
    repeat (8) @(negedge mclk);
    irq_req = 1'b1;
    repeat (12) @(negedge mclk);
    chk("busy", 32'(dev_busy), 32'h1);
    chk("irq held", 32'(irq_active), 32'h0);
    busy_in = 1'b0;
    cnt = 0;
    while (bus.irq_to_device !== 1'b1 && cnt < 40) begin
      cnt++;
      @(negedge mclk);
    end
    irq_req = 1'b0;
    cnt = 0;
    while (bus.irq_to_device === 1'b1 && cnt < 100) begin
      cnt++;
      @(negedge mclk);
    end
    chk("irq width", 32'(cnt >= IIH_CYC), 32'h1);
    chk("irq pulses", 32'(irq_pulses), 32'h1);
    $display("test irq in done");
    {host_irq, more_in, ready_in, done_in, select_in} = 5'h1F;
    repeat (8) @(negedge mclk);
    chk("host irq", 32'(h_irq), 32'h1);
    chk("more", 32'(pio_more), 32'h1);
    chk("gated", {28'h0, h_ready, h_done, mode_a_mode, mode_a_select}, 32'h0);
    mode_in = 1'b1;
    host_irq = 1'b0;
    repeat (8) @(negedge mclk);
    chk("host irq", 32'(h_irq), 32'h0);
    chk("mode_a", {28'h0, h_ready, h_done, mode_a_mode, mode_a_select}, 32'hF);
    $display("test side lines done");
    test_done;
  end
endmodule // tb_system_processor_parallel_port
